// file: fsfb_bank.sv
// Fault status flag bank: thermal, device history and transceiver fault bytes.
// Assumes monitor events are one-cycle pulses on clk; host frames arrive decoded.
`default_nettype none

module fsfb_bank (
	// Clock and reset (rst_n low = power-on or soft reset)
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Decoded serial frame
	input  wire logic       frame_valid,
	input  wire logic [6:0] frame_addr,
	input  wire logic       frame_clear,
	output logic [7:0]      read_data,
	output logic            read_hit,
	// Thermal monitor events
	input  wire logic       severe_thermal_event,
	input  wire logic       first_thermal_event,
	input  wire logic       prewarning_event,
	// Mode controller events
	input  wire logic       restart_fail_event,
	input  wire logic       stop_to_sleep_event,
	input  wire logic       sleep_no_wake_event,
	input  wire logic       sleep_wake_pending_event,
	input  wire logic       sleep_entry_event,
	input  wire logic       invalid_command_event,
	// Watchdog
	input  wire logic [2:0] config_select,
	input  wire logic       watchdog_failure_counter_event,
	input  wire logic       wd_good_trigger,
	input  wire logic       wd_stopped,
	input  wire logic       wd_stop_by_failure,
	// Transceivers
	input  wire logic       lin_fault_event,
	input  wire logic [1:0] lin_fault_code,
	input  wire logic       can_fault_event,
	input  wire logic [1:0] can_fault_code,
	input  wire logic       can_supply_low_event,
	// Outputs to system
	output logic            fail_output,
	output logic            failsafe_request,
	output logic            restart_request,
	output logic            can_tx_disable
);
	import fsfb_pkg::*;

	logic [2:0] therm_reg, therm_next;
	logic [1:0] prev_state_reg, prev_state_next;
	logic [1:0] wdc_reg, wdc_next;
	logic       frozen_reg, frozen_next;
	logic       cmd_fail_reg, cmd_fail_next;
	logic       failure_reg, failure_next;
	logic [1:0] lin_reg, lin_next;
	logic [1:0] can_reg, can_next;
	logic       can_low_reg, can_low_next;
	logic       failout_reg, failout_next;
	logic       fs_reg, fs_next;
	logic       rs_reg, rs_next;
	logic [7:0] rd_reg, rd_next;
	logic       hit_reg, hit_next;

	logic [7:0] therm_byte, dev_byte, bus_byte;
	logic       clr_therm, clr_dev, clr_bus;
	logic       watchdog_failure_counter_drive;

	// Host clear of one byte
	function automatic logic clr_of(input logic v, input logic c, input logic [6:0] a,
		input logic [6:0] t);
		clr_of = v & c & (a == t);
	endfunction : clr_of

	// ****************************************
	// Read view, reserved bits zero
	// ****************************************
	assign therm_byte = {5'h00, therm_reg} & MASK_THERM;
	assign dev_byte   = {prev_state_reg, 2'h0, wdc_reg, cmd_fail_reg, failure_reg};
	assign bus_byte   = {1'b0, lin_reg, 2'h0, can_reg, can_low_reg} & MASK_BUS;
	assign clr_therm  = clr_of(frame_valid, frame_clear, frame_addr, ADDR_THERM);
	assign clr_dev    = clr_of(frame_valid, frame_clear, frame_addr, ADDR_DEV);
	assign clr_bus    = clr_of(frame_valid, frame_clear, frame_addr, ADDR_BUS);

	// Watchdog failure drives fail output at its count: first in config 2, second otherwise
	assign watchdog_failure_counter_drive = watchdog_failure_counter_event & ((config_select == CFG_TWO) | (wdc_reg != WDC_ZERO));

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		// Thermal: set beats clear, hardware never clears
		therm_next = (clr_therm ? 3'h0 : therm_reg)
			| {severe_thermal_event, first_thermal_event, prewarning_event};
		// Previous state, later event wins over clear
		prev_state_next = clr_dev ? PREV_CLEARED : prev_state_reg;
		if (sleep_entry_event | sleep_wake_pending_event)
			prev_state_next = PREV_SLEEP;
		if (restart_fail_event | stop_to_sleep_event | sleep_no_wake_event | severe_thermal_event)
			prev_state_next = PREV_FAIL;
		// Watchdog counter, not host clearable
		wdc_next    = wdc_reg;
		frozen_next = frozen_reg;
		if (wd_good_trigger) begin
			wdc_next    = WDC_ZERO;
			frozen_next = 1'b0;
		end else if (watchdog_failure_counter_event & ~frozen_reg) begin
			if (wdc_reg != WDC_TWO)
				wdc_next = wdc_reg + WDC_ONE;
			if ((config_select == CFG_TWO) | (config_select == CFG_FOUR))
				frozen_next = 1'b1;
		end else if (wd_stopped & ~wd_stop_by_failure) begin
			wdc_next    = WDC_ZERO;
		end
		cmd_fail_next = (cmd_fail_reg & ~clr_dev) | invalid_command_event;
		failout_next  = failout_reg | watchdog_failure_counter_drive | severe_thermal_event;
		failure_next  = (failure_reg & ~clr_dev) | watchdog_failure_counter_drive | severe_thermal_event;
		// Transceiver faults
		lin_next     = lin_fault_event ? lin_fault_code : (clr_bus ? 2'h0 : lin_reg);
		can_next     = can_fault_event ? can_fault_code : (clr_bus ? 2'h0 : can_reg);
		can_low_next = (can_low_reg & ~clr_bus) | can_supply_low_event;
		fs_next      = fs_reg | severe_thermal_event;
		rs_next      = watchdog_failure_counter_event & (config_select == CFG_ZERO) & (wdc_reg == WDC_ZERO);
		// Read returns value before clear
		hit_next = frame_valid & ((frame_addr == ADDR_THERM) | (frame_addr == ADDR_DEV)
			| (frame_addr == ADDR_BUS));
		case (frame_addr)
			ADDR_THERM: rd_next = therm_byte;
			ADDR_DEV:   rd_next = dev_byte;
			ADDR_BUS:   rd_next = bus_byte;
			default:    rd_next = RST_VAL;
		endcase
		if (~frame_valid)
			rd_next = rd_reg;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			therm_reg      <= 3'h0;
			prev_state_reg <= PREV_CLEARED;
			wdc_reg        <= WDC_ZERO;
			frozen_reg     <= 1'b0;
			cmd_fail_reg   <= 1'b0;
			failure_reg    <= 1'b0;
			lin_reg        <= 2'h0;
			can_reg        <= 2'h0;
			can_low_reg    <= 1'b0;
			failout_reg    <= 1'b0;
			fs_reg         <= 1'b0;
			rs_reg         <= 1'b0;
			rd_reg         <= RST_VAL;
			hit_reg        <= 1'b0;
		end else begin
			therm_reg      <= therm_next;
			prev_state_reg <= prev_state_next;
			wdc_reg        <= wdc_next;
			frozen_reg     <= frozen_next;
			cmd_fail_reg   <= cmd_fail_next;
			failure_reg    <= failure_next;
			lin_reg        <= lin_next;
			can_reg        <= can_next;
			can_low_reg    <= can_low_next;
			failout_reg    <= failout_next;
			fs_reg         <= fs_next;
			rs_reg         <= rs_next;
			rd_reg         <= rd_next;
			hit_reg        <= hit_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign read_data        = rd_reg;
	assign read_hit         = hit_reg;
	assign fail_output      = failout_reg;
	assign failsafe_request = fs_reg;
	assign restart_request  = rs_reg;
	assign can_tx_disable   = can_low_reg;
endmodule : fsfb_bank

`default_nettype wire

// file: fsfb_pkg.sv
// Constants for the fault status flag bank.
// Assumes a serial command decoder on the same clock delivers frame strobes.
`default_nettype none

package fsfb_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [6:0] ADDR_THERM = 7'h42;
	localparam logic [6:0] ADDR_DEV   = 7'h43;
	localparam logic [6:0] ADDR_BUS   = 7'h44;
	// ****************************************
	// Clearable masks and reset
	// ****************************************
	localparam logic [7:0] MASK_THERM = 8'h07;
	localparam logic [7:0] MASK_DEV   = 8'hc3;
	localparam logic [7:0] MASK_BUS   = 8'h67;
	localparam logic [7:0] RST_VAL    = 8'h00;
	// ****************************************
	// Field codes
	// ****************************************
	localparam logic [1:0] PREV_CLEARED = 2'h0;
	localparam logic [1:0] PREV_FAIL    = 2'h1;
	localparam logic [1:0] PREV_SLEEP   = 2'h2;
	localparam logic [1:0] WDC_ZERO     = 2'h0;
	localparam logic [1:0] WDC_ONE      = 2'h1;
	localparam logic [1:0] WDC_TWO      = 2'h2;
	localparam logic [2:0] CFG_ZERO     = 3'h0;
	localparam logic [2:0] CFG_TWO      = 3'h2;
	localparam logic [2:0] CFG_FOUR     = 3'h4;
endpackage : fsfb_pkg

`default_nettype wire

// file: fsfb_host.sv
// Host model: sends one decoded frame and takes the answer byte.
// Assumes the bank answers one clk cycle after the frame.
`default_nettype none
module fsfb_host (
	// Frame port
	input  wire logic       clk,
	input  wire logic [7:0] read_data,
	output logic            frame_valid,
	output logic [6:0]      frame_addr,
	output logic            frame_clear
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle lines from time zero
	initial frame_valid = 1'b0;
	initial frame_addr = 7'h00;
	initial frame_clear = 1'b0;
	// Frame held one edge, byte taken at the next
	task automatic access(input logic [6:0] a, input logic c, output logic [7:0] d);
		@(posedge clk);
		frame_valid <= 1'b1;
		frame_addr  <= a;
		frame_clear <= c;
		@(posedge clk);
		frame_valid <= 1'b0;
		#1;
		d = read_data;
	endtask : access
endmodule : fsfb_host
`default_nettype wire

// file: fsfb_bank_props.sv
// Checker: frame answers, reserved bits and sticky outputs.
// Assumes one clk domain, rst_n synchronous active low.
`default_nettype none
module fsfb_bank_props import fsfb_pkg::*; (
	input wire logic       clk, rst_n, frame_valid, read_hit,
	input wire logic [6:0] frame_addr,
	input wire logic [7:0] read_data,
	input wire logic       severe_thermal_event, can_supply_low_event,
	input wire logic       fail_output, failsafe_request, can_tx_disable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Frame to a mapped byte
	wire logic hit = frame_valid && (frame_addr inside {ADDR_THERM, ADDR_DEV, ADDR_BUS});
	property p_hit; hit |=> read_hit; endproperty
	a_hit: assert property (p_hit) else $error("no hit");
	property p_miss; frame_valid && !hit |=> !read_hit && read_data == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read");
	property p_rsvt; frame_valid && frame_addr == ADDR_THERM |=> read_data[7:3] == 5'h00; endproperty
	a_rsvt: assert property (p_rsvt) else $error("thermal reserved");
	property p_rsvd; frame_valid && frame_addr == ADDR_DEV |=> read_data[5:4] == 2'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("device reserved");
	property p_hold; !frame_valid |=> $stable(read_data); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_safe; severe_thermal_event |-> ##[1:2] (failsafe_request && fail_output); endproperty
	a_safe: assert property (p_safe) else $error("no fail-safe");
	property p_stick; failsafe_request |=> failsafe_request [*3]; endproperty
	a_stick: assert property (p_stick) else $error("fail-safe dropped");
	property p_can; can_supply_low_event |-> ##[1:2] can_tx_disable; endproperty
	a_can: assert property (p_can) else $error("can tx on");
endmodule : fsfb_bank_props
bind fsfb_bank fsfb_bank_props u_fsfb_bank_props (.clk, .rst_n, .frame_valid, .read_hit, .frame_addr, .read_data,
	.severe_thermal_event, .can_supply_low_event, .fail_output, .failsafe_request, .can_tx_disable);
`default_nettype wire

// file: fsfb_tb.sv
// Testbench: pulses flag events, reads bytes through the host model.
// Assumes package, bank, host and checker compiled first.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import fsfb_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, frame_valid, frame_clear, read_hit;
	logic        fail_output, failsafe_request, restart_request, can_tx_disable;
	logic [6:0]  frame_addr;
	logic [7:0]  read_data;
	logic [13:0] ev = 14'h0;
	logic [2:0]  cfg = 3'h1;
	logic [1:0]  code = 2'h0;
	int          miscompares = 0, comparisons = 0;
	// Clock, host and bank
	initial forever #4 clk = ~clk;
	fsfb_host u_fsfb_host (.*);
	fsfb_bank u_fsfb_bank (.*, .severe_thermal_event(ev[0]), .first_thermal_event(ev[1]), .prewarning_event(ev[2]),
		.restart_fail_event(ev[3]), .stop_to_sleep_event(ev[4]), .sleep_no_wake_event(ev[5]),
		.sleep_wake_pending_event(ev[6]), .sleep_entry_event(ev[7]), .invalid_command_event(ev[8]),
		.config_select(cfg), .watchdog_failure_counter_event(ev[9]), .wd_good_trigger(ev[10]), .wd_stopped(1'b0),
		.wd_stop_by_failure(1'b0), .lin_fault_event(ev[11]), .lin_fault_code(code), .can_fault_event(ev[12]),
		.can_fault_code(code), .can_supply_low_event(ev[13]));
	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] d;
		u_fsfb_host.access(a, c, d);
		chk("read_data", d & m, e);
	endtask : rd
	task automatic pulse(input logic [13:0] p);
		@(posedge clk);
		ev <= p;
		@(posedge clk);
		ev <= 14'h0;
		#1;
	endtask : pulse
	task automatic rst();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask : rst
	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic t_therm();
		for (int a = 'h42; a <= 'h45; a++) rd(7'(a), 1'b0, 8'h00, 8'hff);
		pulse(14'h7);
		rd(ADDR_THERM, 1'b1, 8'h07, 8'hff);
		fork
			rd(ADDR_THERM, 1'b1, 8'h00, 8'hff);
			pulse(14'h4);
		join
		rd(ADDR_THERM, 1'b0, 8'h01, 8'hff);
		rd(ADDR_DEV, 1'b0, 8'h41, 8'hff);
	endtask : t_therm
	task automatic t_dev();
		rst();
		for (int i = 3; i <= 8; i++) begin
			pulse(14'h1 << i);
			rd(ADDR_DEV, 1'b1, (i == 8) ? 8'h02 : (i < 6) ? 8'h40 : 8'h80, 8'hff);
		end
		pulse(14'h90);
		rd(ADDR_DEV, 1'b1, 8'h40, 8'hff);
		rd(ADDR_DEV, 1'b0, 8'h00, 8'hff);
	endtask : t_dev
	task automatic t_wd();
		rst();
		pulse(14'h200);
		rd(ADDR_DEV, 1'b1, 8'h04, 8'h0d);
		pulse(14'h200);
		rd(ADDR_DEV, 1'b0, 8'h09, 8'h0d);
		rst();
		cfg <= CFG_TWO;
		pulse(14'h200);
		pulse(14'h200);
		rd(ADDR_DEV, 1'b0, 8'h05, 8'h0d);
		pulse(14'h400);
		rd(ADDR_DEV, 1'b0, 8'h00, 8'h0c);
		rst();
		cfg <= CFG_ZERO;
		pulse(14'h200);
		chk("restart", {6'h0, restart_request, fail_output}, 8'h02);
		rd(ADDR_DEV, 1'b0, 8'h00, 8'h01);
	endtask : t_wd
	task automatic t_xcvr();
		for (int k = 1; k <= 3; k++) begin
			@(posedge clk);
			code <= 2'(k);
			pulse(14'h3800);
			rd(ADDR_BUS, 1'b1, {1'b0, 2'(k), 2'h0, 2'(k), 1'b1}, 8'hff);
		end
		rd(ADDR_BUS, 1'b0, 8'h00, 8'hff);
	endtask : t_xcvr
	// Main sequence and hang guard
	initial begin
		rst();
		t_therm();
		t_dev();
		t_wd();
		t_xcvr();
		stop_test();
	end
	initial begin
		#40000;
		miscompares++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
